/* src/scan_seq_defines.vh */
// Purpose: Shared constants for the scan-mode sequencer
// Assumes: Included by the sequencer top and nothing else needs more
// Notes: Register offsets are word indices on the plain register port
`ifndef SCAN_SEQ_DEFINES_VH
`define SCAN_SEQ_DEFINES_VH

// Control word layout (16-bit frame, MSB first)
`define FRAME_BITS 5'h10
`define CW_REGSEL 15
`define CW_SCAN_HI 14
`define CW_SCAN_LO 11
`define CW_SEL_HI 10
`define CW_SEL_LO 7

// Scan-mode codes
`define SCAN_MANUAL 4'h1
`define SCAN_STD_EXT 4'h4
`define SCAN_UPPER_INT 4'h5
`define SCAN_UPPER_EXT 4'h6
`define SCAN_CUSTOM_INT 4'h7
`define SCAN_CUSTOM_EXT 4'h8
`define SCAN_PATTERN 4'h9

// Reset values
`define MODE_RESET 4'h1
`define SEL_CODE_RESET 4'h0
`define MASK_RESET 16'h0001
`define PLEN_RESET 8'h00

// Register indices
`define REG_CTRL 4'h0
`define REG_MASK 4'h1
`define REG_PLEN 4'h2
`define REG_PWRITE 4'h3
`define REG_STATUS 4'h4

// Field positions and top channels
`define CTRL_EIGHT 0
`define CTRL_AVG 1
`define TOP_16 4'hF
`define TOP_8 4'h7

`endif

/* src/pin_sync.v */
// Purpose: Two-flop synchroniser with a third stage for edge detection
// Assumes: Inputs are asynchronous to clk
// Notes: Only the second and third stages are visible outside
module pin_sync #(
  parameter W = 3,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Pins in, synchronised levels out
  input wire [W-1:0] din,
  output reg [W-1:0] sync_q,
  output reg [W-1:0] prev_q
);
  reg [W-1:0] meta_q;

  // Metastable stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_q <= INIT;
      prev_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
endmodule

/* src/scan_sequencer.v */
// Purpose: Serial-controlled channel scan sequencer of a multichannel converter
// Assumes: SCLK and CS_N are slow pins sampled by MCLK; front end answers CONV_REQ
// Notes: Results leave as {channel, 12-bit data} words, one per frame
`include "scan_seq_defines.vh"
module scan_sequencer (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // Serial link
  input wire SCLK,
  input wire CS_N,
  input wire DIN,
  output wire DOUT,
  // Register port
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  // Conversion front end
  output reg CONV_REQ,
  output reg [3:0] CONV_CH,
  output reg CONV_AVG,
  input wire CONV_VALID,
  input wire [11:0] CONV_DATA
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  wire [2:0] pins_s;
  wire [2:0] pins_p;
  reg [15:0] rx_q;
  reg [4:0] bits_q;
  reg [15:0] tx_sh_q;
  reg [15:0] tx_word_q;
  reg [3:0] mode_q;
  reg [3:0] sel_code_q;
  reg [3:0] pos_q;
  reg [7:0] idx_q;
  reg [15:0] mask_q;
  reg [7:0] plen_q;
  reg eight_q;
  reg avg_en_q;
  reg st_q;
  reg run_q;
  reg [4:0] wr_q;
  reg [4:0] rd_q;
  reg [15:0] res_buf [0:15];
  reg [3:0] pat_mem [0:255];

  // Unsigned channel number decode
  function [3:0] chan_of;
    input [3:0] code;
    begin
      chan_of = code;
    end
  endfunction

  // Codes that replace the mode; all others leave it standing
  function code_ok;
    input [3:0] code;
    begin
      code_ok = (code == `SCAN_MANUAL) || (code >= `SCAN_STD_EXT && code <= `SCAN_PATTERN);
    end
  endfunction

  function is_internal;
    input [3:0] m;
    begin
      is_internal = (m == `SCAN_UPPER_INT) || (m == `SCAN_CUSTOM_INT);
    end
  endfunction

  // Lowest enabled channel of the custom list
  function [3:0] low_bit;
    input [15:0] mask;
    integer i;
    begin
      low_bit = 4'h0;
      for (i = 15; i >= 0; i = i - 1) begin
        if (mask[i]) begin
          low_bit = i[3:0];
        end
      end
    end
  endfunction

  // First channel of a sequence
  function [3:0] first_ch;
    input [3:0] m;
    input [3:0] n;
    input [15:0] mask;
    begin
      case (m)
        `SCAN_STD_EXT: first_ch = 4'h0;
        `SCAN_UPPER_INT, `SCAN_UPPER_EXT: first_ch = n;
        `SCAN_CUSTOM_INT, `SCAN_CUSTOM_EXT: first_ch = low_bit(mask);
        default: first_ch = n;
      endcase
    end
  endfunction

  // Following channel; wraps to the first after the last
  function [3:0] next_ch;
    input [3:0] m;
    input [3:0] ch;
    input [3:0] n;
    input [15:0] mask;
    input [3:0] top;
    integer i;
    begin
      case (m)
        `SCAN_STD_EXT: next_ch = (ch >= n) ? 4'h0 : ch + 4'h1;
        `SCAN_UPPER_INT, `SCAN_UPPER_EXT: next_ch = (ch >= top) ? n : ch + 4'h1;
        `SCAN_CUSTOM_INT, `SCAN_CUSTOM_EXT: begin
          next_ch = low_bit(mask);
          for (i = 15; i >= 0; i = i - 1) begin
            if (mask[i] && i[3:0] > ch) begin
              next_ch = i[3:0];
            end
          end
        end
        default: next_ch = ch;
      endcase
    end
  endfunction

  pin_sync #(.W(3), .INIT(3'h2)) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .din({SCLK, CS_N, DIN}),
    .sync_q(pins_s),
    .prev_q(pins_p)
  );

  wire sclk_rise = pins_s[2] & ~pins_p[2] & ~pins_s[1];
  wire sclk_fall = ~pins_s[2] & pins_p[2] & ~pins_s[1];
  wire frame_start = ~pins_s[1] & pins_p[1];
  wire frame_end = pins_s[1] & ~pins_p[1];
  wire [3:0] top = eight_q ? `TOP_8 : `TOP_16;

  // Command taken only from a full mode-control frame
  wire take = frame_end && (bits_q >= `FRAME_BITS) && !rx_q[`CW_REGSEL] &&
    code_ok(rx_q[`CW_SCAN_HI:`CW_SCAN_LO]);
  wire [3:0] mode_n = take ? rx_q[`CW_SCAN_HI:`CW_SCAN_LO] : mode_q;
  wire [3:0] sel_code_n = take ? chan_of(rx_q[`CW_SEL_HI:`CW_SEL_LO]) : sel_code_q;
  wire [3:0] pos_now = take ? first_ch(mode_n, sel_code_n, mask_q) : pos_q;
  wire [7:0] idx_now = take ? 8'h00 : idx_q;
  wire buf_empty = (rd_q == wr_q);
  wire last_conv = next_ch(mode_q, CONV_CH, sel_code_q, mask_q, top) <= CONV_CH;

  // Serial shifter; DOUT changes on falling SCLK, DIN taken on rising
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_q <= 16'h0000;
      bits_q <= 5'h00;
      tx_sh_q <= 16'h0000;
    end else if (frame_start) begin
      bits_q <= 5'h00;
      tx_sh_q <= tx_word_q;
    end else begin
      if (sclk_rise) begin
        rx_q <= {rx_q[14:0], pins_s[0]};
        if (bits_q < `FRAME_BITS) begin
          bits_q <= bits_q + 5'h01;
        end
      end
      if (sclk_fall) begin
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
      end
    end
  end

  assign DOUT = tx_sh_q[15];

  // Pattern entries are loaded by software; no reset needed
  always @(posedge MCLK) begin
    if (WR && ADDR == `REG_PWRITE) begin
      pat_mem[WDATA[7:0]] <= WDATA[11:8];
    end
  end

  // Register writes and read data one cycle later
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      eight_q <= 1'b0;
      avg_en_q <= 1'b0;
      mask_q <= `MASK_RESET;
      plen_q <= `PLEN_RESET;
      RDATA <= 32'h00000000;
    end else begin
      if (WR && ADDR == `REG_CTRL) begin
        eight_q <= WDATA[`CTRL_EIGHT];
        avg_en_q <= WDATA[`CTRL_AVG];
      end
      if (WR && ADDR == `REG_MASK) begin
        mask_q <= WDATA[15:0];
      end
      if (WR && ADDR == `REG_PLEN) begin
        plen_q <= WDATA[7:0];
      end
      RDATA <= 32'h00000000;
      if (RD) begin
        case (ADDR)
          `REG_CTRL: RDATA <= {30'h0, avg_en_q, eight_q};
          `REG_MASK: RDATA <= {16'h0000, mask_q};
          `REG_PLEN: RDATA <= {24'h000000, plen_q};
          `REG_STATUS: RDATA <= {13'h0, st_q, run_q, wr_q - rd_q,
            CONV_CH, sel_code_q, mode_q};
          default: RDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // Mode state, frame actions and conversion handshake
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= `MODE_RESET;
      sel_code_q <= `SEL_CODE_RESET;
      pos_q <= 4'h0;
      idx_q <= 8'h00;
      st_q <= ST_IDLE;
      run_q <= 1'b0;
      wr_q <= 5'h00;
      rd_q <= 5'h00;
      tx_word_q <= 16'h0000;
      CONV_REQ <= 1'b0;
      CONV_CH <= 4'h0;
      CONV_AVG <= 1'b0;
    end else begin
      CONV_REQ <= 1'b0;
      if (frame_end) begin
        mode_q <= mode_n;
        sel_code_q <= sel_code_n;
      end
      case (st_q)
        ST_IDLE: begin
          if (frame_end) begin
            if (mode_n == `SCAN_MANUAL) begin
              CONV_CH <= sel_code_n;
              CONV_AVG <= 1'b0;
              CONV_REQ <= 1'b1;
              st_q <= ST_WAIT;
            end else if (mode_n == `SCAN_PATTERN) begin
              CONV_CH <= pat_mem[idx_now];
              CONV_AVG <= 1'b0;
              CONV_REQ <= 1'b1;
              st_q <= ST_WAIT;
              idx_q <= (idx_now >= plen_q) ? 8'h00 : idx_now + 8'h01;
            end else if (is_internal(mode_n)) begin
              if (!take && !buf_empty) begin
                tx_word_q <= res_buf[rd_q[3:0]];
                rd_q <= rd_q + 5'h01;
              end else begin
                CONV_CH <= first_ch(mode_n, sel_code_n, mask_q);
                CONV_AVG <= avg_en_q;
                CONV_REQ <= 1'b1;
                run_q <= 1'b1;
                wr_q <= 5'h00;
                rd_q <= 5'h00;
                st_q <= ST_WAIT;
              end
            end else begin
              CONV_CH <= pos_now;
              CONV_AVG <= 1'b0;
              CONV_REQ <= 1'b1;
              st_q <= ST_WAIT;
              pos_q <= next_ch(mode_n, pos_now, sel_code_n, mask_q, top);
            end
          end
        end
        ST_WAIT: begin
          if (CONV_VALID) begin
            if (run_q) begin
              res_buf[wr_q[3:0]] <= {CONV_CH, CONV_DATA};
              wr_q <= wr_q + 5'h01;
              if (last_conv || wr_q >= 5'h0F) begin
                run_q <= 1'b0;
                st_q <= ST_IDLE;
              end else begin
                CONV_CH <= next_ch(mode_q, CONV_CH, sel_code_q, mask_q, top);
                CONV_REQ <= 1'b1;
              end
            end else begin
              tx_word_q <= {CONV_CH, CONV_DATA};
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

/* dv/scan_seq_monitor.sv */
// Purpose: Port checks for the scan sequencer
// Assumes: One domain, MCLK with RST_N
// Notes: Counters time pin edges as seen here
module scan_seq_monitor (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // Serial pins
  input wire SCLK,
  input wire CS_N,
  input wire DOUT,
  // Register port
  input wire [3:0] ADDR,
  input wire RD,
  input wire [31:0] RDATA,
  // Front end
  input wire CONV_REQ,
  input wire [3:0] CONV_CH,
  input wire CONV_AVG,
  input wire CONV_VALID
);
  timeunit 1ns;
  timeprecision 100ps;
  reg cs_q;
  reg sck_q;
  reg [3:0] cs_cnt_q;
  reg [3:0] edge_cnt_q;
  wire cs_rise = CS_N && !cs_q;
  wire shift_edge = (!CS_N && cs_q) || (!SCLK && sck_q);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Saturating ages of frame end and shift edge
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      cs_cnt_q <= 4'hF;
      edge_cnt_q <= 4'hF;
    end else begin
      cs_q <= CS_N;
      sck_q <= SCLK;
      cs_cnt_q <= cs_rise ? 4'h0 : cs_cnt_q + {3'h0, cs_cnt_q != 4'hF};
      edge_cnt_q <= shift_edge ? 4'h0 : edge_cnt_q + {3'h0, edge_cnt_q != 4'hF};
    end
  end
  req_pulse_a: assert property (CONV_REQ |=> !CONV_REQ)
    else $error("request held over one cycle");
  req_cause_a: assert property (CONV_REQ |-> cs_cnt_q < 4'h9 || $past(CONV_VALID))
    else $error("request without frame end or result");
  dout_edge_a: assert property ($changed(DOUT) |-> edge_cnt_q < 4'h8)
    else $error("serial out moved off its edges");
  ch_hold_a: assert property ($changed(CONV_CH) |-> CONV_REQ)
    else $error("channel moved without request");
  avg_hold_a: assert property ($changed(CONV_AVG) |-> CONV_REQ)
    else $error("averaging moved without request");
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (RD && ADDR > 4'h4 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  status_ch_a: assert property (RD && ADDR == 4'h4 |=> RDATA[11:8] == $past(CONV_CH))
    else $error("status channel wrong");
  cover property (CONV_REQ && CONV_AVG);
  cover property (RD && ADDR == 4'h4);
  cover property (cs_rise);
endmodule

/* dv/serial_host_model.sv */
// Purpose: Serial host framing control words
// Assumes: 125 ns link clock, still between frames
// Notes: Data pin shows inverse of last bit when idle
module serial_host_model (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] rx_q;
  event rx_done;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Names next channel each frame, takes last result
  task automatic xfer(input logic [15:0] w);
    #0.3; // Pin moves stay off the MCLK edges
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      #62.5 sclk = 1'b1;
      rx_q[i] = dout;
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    din = ~din;
    ->rx_done;
    #999.2; // Room for the conversion; whole frame ends on a whole ns
  endtask
endmodule

/* dv/scan_sequencer_tb.sv */
// Purpose: Self-checking bench for the scan sequencer
// Assumes: Front end answers after random latency
// Notes: Expected results queue up, a watcher compares
module scan_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic conv_valid = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [11:0] conv_data = 12'h000;
  logic [31:0] rdata;
  logic [31:0] r;
  logic [3:0] conv_ch;
  logic conv_req, conv_avg, sclk, cs_n, din, dout;
  logic [11:0] dat [16];
  logic [4:0] exp_ch [$];
  logic [15:0] exp_rx [$];
  logic [16:0] exp_rd [$];
  integer seed = 32'h7AB0A12A;
  int fails = 0;
  int total_checks = 0;
  scan_sequencer u_dut (.MCLK(mclk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
    .DOUT(dout), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CONV_REQ(conv_req), .CONV_CH(conv_ch), .CONV_AVG(conv_avg),
    .CONV_VALID(conv_valid), .CONV_DATA(conv_data));
  serial_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  initial forever #4 mclk = ~mclk;
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [16:0] e);
    exp_rd.push_back(e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  function automatic logic [15:0] cw(input logic [3:0] c, input logic [3:0] n);
    return {1'b0, c, n, 7'h00};
  endfunction
  // Command frame, then reserved-code frames with junk low bits
  task automatic run(input logic [15:0] w, input int nf, input int ne, input logic avg,
                     input logic [63:0] seq);
    for (int i = 0; i < ne; i++) exp_ch.push_back({avg, seq[4*i +: 4]});
    u_host.xfer(w);
    for (int i = 1; i < nf; i++) u_host.xfer({1'b0, 4'(10 + (i - 1) % 6), 11'h7FF});
  endtask
  // Front end: random latency and data, junk between results
  always @(posedge mclk) begin
    if (conv_req) begin
      r = $random(seed);
      repeat (int'(r[1:0]) + 2) @(posedge mclk);
      dat[conv_ch] = r[15:4];
      conv_data <= r[15:4];
      conv_valid <= 1'b1;
      @(posedge mclk);
      conv_valid <= 1'b0;
      conv_data <= ~r[15:4];
    end
  end
  // Watcher: oldest note against each request and each read
  always @(posedge mclk) begin
    rd_d <= rd;
    if (conv_req) check(32'({conv_avg, conv_ch}), 32'(exp_ch.size() > 0 ? exp_ch.pop_front() : 5'bx));
    if (rd_d) check(32'(rdata[16:0]), 32'(exp_rd.pop_front()));
  end
  always @(u_host.rx_done) begin
    if (exp_rx.size() > 0) check(32'(u_host.rx_q), 32'(exp_rx.pop_front()));
  end
  initial begin
    #400us;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_reg(4'h1, 17'h00001);
    rd_reg(4'h7, 17'h00000);
    wr_reg(4'h0, 32'h2);
    $display("registers done");
    // Manual: every channel code, result one frame later
    for (int c = 0; c < 16; c++) begin
      exp_ch.push_back({1'b0, 4'(c)});
      u_host.xfer(cw(4'h1, 4'(c)));
      exp_rx.push_back({4'(c), dat[c]});
    end
    $display("manual done");
    run(cw(4'h4, 4'h2), 5, 5, 1'b0, 64'h10210);
    run(cw(4'h6, 4'hE), 3, 3, 1'b0, 64'hEFE);
    wr_reg(4'h1, 32'h0105);
    run(cw(4'h8, 4'h0), 4, 4, 1'b0, 64'h0820);
    wr_reg(4'h2, 32'h2);
    wr_reg(4'h3, 32'h700);
    wr_reg(4'h3, 32'h701);
    wr_reg(4'h3, 32'h302);
    run(cw(4'h9, 4'h0), 4, 4, 1'b0, 64'h7377);
    $display("external scans done");
    // Two reserved frames pop the first two buffered results
    run(cw(4'h5, 4'hD), 2, 3, 1'b1, 64'hFED);
    exp_rx.push_back({4'hD, dat[13]});
    u_host.xfer(16'h5FFF);
    rd_reg(4'h4, 17'h01FD5);
    run(cw(4'h7, 4'h0), 1, 3, 1'b1, 64'h820);
    rd_reg(4'h4, 17'h03807);
    repeat (4) @(posedge mclk);
    $display("internal scans done");
    check(32'(exp_ch.size() + exp_rx.size() + exp_rd.size()), 32'h0);
    report_and_stop();
  end
endmodule
bind scan_sequencer scan_seq_monitor u_mon (.MCLK(MCLK), .RST_N(RST_N), .SCLK(SCLK),
  .CS_N(CS_N), .DOUT(DOUT), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .CONV_REQ(CONV_REQ),
  .CONV_CH(CONV_CH), .CONV_AVG(CONV_AVG), .CONV_VALID(CONV_VALID));
